// ===== rtl/dsr_drive_status_register_bank.sv
// Operation
// - parameters 4 to 60 sit at holding register 128 plus parameter number
// - every configuration parameter register can be read and written
// - status bit 0 ready: no trip, no mains loss, hardware enabled
// - status bits 1, 2, 3: running, tripped, standby
// - status bit 4 follows fire-override mode
// - status bit 6: enabled and output speed equals setpoint
// - status bit 7: enabled and output speed magnitude below minimum speed
// - status bit 8: motor current above rated current parameter
// - status bit 9: mains supply loss detected
// - status bit 10: heatsink above 85 degrees
// - status bit 11: control board above 80 degrees
// - status bit 12: switching frequency foldback active
// - status bit 13: output speed negative
// - status bit 15 inverts on every read of the status word
// - io bits 0 to 3 follow digital inputs one to four
// - io bit 2 is input three, bit 3 is input four
// - io bits 6 and 7 follow forward and reverse switches
// - io bit 8: digital output active or analogue output above zero
// - io bit 9 follows the user relay contact
// - io bits 12 and 13 flag current-loop loss on analogue inputs
// - io bit 15: front potentiometer above half scale
`timescale 1ns/100ps
`default_nettype none
module dsr_drive_status_register_bank (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  input  wire dsr_pkg::dsr_req_type  i_req,
  output dsr_pkg::dsr_rsp_type       o_rsp,
  input  wire dsr_pkg::dsr_drive_type i_drive,
  input  wire dsr_pkg::dsr_io_type   i_io,
  input  wire dsr_pkg::dsr_meas_type i_meas,
  output logic      [15:0]           o_drive_status,
  output logic      [15:0]           o_io_status
);

  typedef enum logic [1:0] {
    DSR_SEL_NONE,
    DSR_SEL_MON,
    DSR_SEL_PARAM
  } dsr_sel_type;

  logic        rst_meta_r;
  logic        rst_n_r;
  logic [15:0] status_r;
  logic [15:0] io_r;
  logic        live_r;
  dsr_pkg::dsr_meas_type meas_r;
  dsr_pkg::dsr_rsp_type  rsp_r;
  logic [15:0] status_nxt;
  logic [15:0] io_nxt;
  logic [15:0] rated_current;
  logic [15:0] param_rdata;
  logic [5:0]  param_idx;
  logic        param_wr;
  logic        status_read;
  logic        ready_cond;
  logic [15:0] speed_mag;
  dsr_sel_type sel;

  // reset released through two flops so every state flop leaves reset together
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  function automatic logic is_param_reg(input logic [15:0] num);
    is_param_reg = num >= (dsr_pkg::PARAM_REG_BASE + dsr_pkg::PARAM_FIRST) &&
                   num <= (dsr_pkg::PARAM_REG_BASE + dsr_pkg::PARAM_LAST);
  endfunction

  function automatic logic is_mon_reg(input logic [15:0] num);
    is_mon_reg = num == dsr_pkg::REG_DRIVE_STATUS_WORD ||
                 (num >= dsr_pkg::REG_IO_STATUS_WORD && num <= dsr_pkg::REG_FAULT_CODE);
  endfunction

  always_comb begin
    if (is_mon_reg(i_req.reg_num)) begin
      sel = DSR_SEL_MON;
    end else if (is_param_reg(i_req.reg_num)) begin
      sel = DSR_SEL_PARAM;
    end else begin
      sel = DSR_SEL_NONE;
    end
  end

  assign param_idx   = 6'(i_req.reg_num - dsr_pkg::PARAM_REG_BASE - dsr_pkg::PARAM_FIRST);
  assign param_wr    = i_req.valid && i_req.write && sel == DSR_SEL_PARAM;
  assign status_read = i_req.valid && !i_req.write &&
                       i_req.reg_num == dsr_pkg::REG_DRIVE_STATUS_WORD;

  dsr_param_store u_params (
    .i_clk           (i_clk),
    .i_rst_n         (rst_n_r),
    .i_ce            (i_ce),
    .i_wr            (param_wr),
    .i_idx           (param_idx),
    .i_wdata         (i_req.wdata),
    .i_rd_idx        (param_idx),
    .o_rdata         (param_rdata),
    .o_rated_current (rated_current)
  );

  assign ready_cond = !i_drive.trip && !i_drive.mains_loss && i_drive.hw_enable;
  assign speed_mag  = i_drive.out_speed[15] ? 16'(-i_drive.out_speed) : i_drive.out_speed;

  always_comb begin
    status_nxt                        = dsr_pkg::STATUS_RESET;
    status_nxt[dsr_pkg::DS_READY]     = ready_cond;
    status_nxt[dsr_pkg::DS_RUNNING]   = i_drive.running;
    status_nxt[dsr_pkg::DS_TRIPPED]   = i_drive.trip;
    status_nxt[dsr_pkg::DS_STANDBY]   = i_drive.standby;
    status_nxt[dsr_pkg::DS_FIRE_MODE] = i_drive.fire_mode;
    status_nxt[dsr_pkg::DS_AT_SPEED]  = i_drive.drive_enabled &&
                                        i_drive.out_speed == i_drive.speed_setpoint;
    status_nxt[dsr_pkg::DS_BELOW_MIN] = i_drive.drive_enabled &&
                                        speed_mag < i_drive.min_speed;
    status_nxt[dsr_pkg::DS_OVERLOAD]  = i_drive.motor_current > rated_current;
    status_nxt[dsr_pkg::DS_MAINS_LOSS] = i_drive.mains_loss;
    status_nxt[dsr_pkg::DS_HS_HOT]    = i_meas.heatsink_temp > dsr_pkg::HEATSINK_LIMIT_C;
    status_nxt[dsr_pkg::DS_BOARD_HOT] = i_meas.board_temp > dsr_pkg::BOARD_LIMIT_C;
    status_nxt[dsr_pkg::DS_FOLDBACK]  = i_drive.foldback;
    status_nxt[dsr_pkg::DS_REVERSE]   = i_drive.out_speed < 16'sh0000;
  end

  always_comb begin
    io_nxt                              = dsr_pkg::STATUS_RESET;
    io_nxt[dsr_pkg::IO_DIN_LSB +: 4]    = i_io.digital_in;
    io_nxt[dsr_pkg::IO_SW_FWD]          = i_io.switch_fwd;
    io_nxt[dsr_pkg::IO_SW_REV]          = i_io.switch_rev;
    io_nxt[dsr_pkg::IO_DOUT]            = i_io.digital_out_active ||
                                          i_meas.analog_out_level != 16'h0000;
    io_nxt[dsr_pkg::IO_RELAY]           = i_io.relay_closed;
    io_nxt[dsr_pkg::IO_AIN1_LOSS]       = i_io.analog_in_one_loss;
    io_nxt[dsr_pkg::IO_AIN2_LOSS]       = i_io.analog_in_two_loss;
    io_nxt[dsr_pkg::IO_POT_HALF]        = i_meas.front_pot_raw > dsr_pkg::POT_HALF_SCALE;
  end

  // flags sampled every enabled cycle; the live bit is kept apart from them
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= dsr_pkg::STATUS_RESET;
      io_r     <= dsr_pkg::STATUS_RESET;
      meas_r   <= '0;
    end else if (i_ce) begin
      status_r <= status_nxt;
      io_r     <= io_nxt;
      meas_r   <= i_meas;
    end
  end

  // the reply carries the old value, the flip is seen by the next read
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      live_r <= 1'b0;
    end else if (i_ce && status_read) begin
      live_r <= !live_r;
    end
  end

  // monitoring registers are read only; a write there is answered with an error
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rsp_r <= '0;
    end else if (i_ce) begin
      rsp_r.valid <= i_req.valid;
      rsp_r.err   <= i_req.valid && (sel == DSR_SEL_NONE ||
                     (sel == DSR_SEL_MON && i_req.write));
      rsp_r.rdata <= 16'h0000;
      if (i_req.valid && !i_req.write) begin
        unique case (sel)
          DSR_SEL_PARAM: rsp_r.rdata <= param_rdata;
          DSR_SEL_MON: begin
            unique case (i_req.reg_num)
              dsr_pkg::REG_DRIVE_STATUS_WORD: begin
                rsp_r.rdata <= {live_r, status_r[14:0]};
              end
              dsr_pkg::REG_IO_STATUS_WORD:    rsp_r.rdata <= io_r;
              dsr_pkg::REG_OUTPUT_TORQUE:     rsp_r.rdata <= meas_r.output_torque;
              dsr_pkg::REG_DC_LINK_VOLTAGE:   rsp_r.rdata <= meas_r.dc_link_voltage;
              dsr_pkg::REG_HEATSINK_TEMP:     rsp_r.rdata <= meas_r.heatsink_temp;
              dsr_pkg::REG_ANALOG_IN_ONE_RAW: rsp_r.rdata <= meas_r.analog_in_one_raw;
              dsr_pkg::REG_ANALOG_IN_TWO_RAW: rsp_r.rdata <= meas_r.analog_in_two_raw;
              dsr_pkg::REG_ANALOG_OUT_LEVEL:  rsp_r.rdata <= meas_r.analog_out_level;
              dsr_pkg::REG_LOOP_CTRL_OUTPUT:  rsp_r.rdata <= meas_r.loop_controller_output;
              dsr_pkg::REG_BOARD_TEMP:        rsp_r.rdata <= meas_r.board_temp;
              dsr_pkg::REG_OUTPUT_VOLTAGE:    rsp_r.rdata <= meas_r.output_voltage;
              dsr_pkg::REG_FRONT_POT_RAW:     rsp_r.rdata <= meas_r.front_pot_raw;
              dsr_pkg::REG_FAULT_CODE:        rsp_r.rdata <= meas_r.fault_code;
              default:                        rsp_r.rdata <= 16'h0000;
            endcase
          end
          DSR_SEL_NONE:  rsp_r.rdata <= 16'h0000;
        endcase
      end
    end
  end

  assign o_rsp          = rsp_r;
  assign o_drive_status = {live_r, status_r[14:0]};
  assign o_io_status    = io_r;

  // checks stay off until the local reset copy is released
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n_r);

  property p_ready;
    i_ce |=> status_r[dsr_pkg::DS_READY] ==
             (!$past(i_drive.trip) && !$past(i_drive.mains_loss) && $past(i_drive.hw_enable));
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");

  property p_trip_not_ready;
    i_ce && i_drive.trip |=> status_r[dsr_pkg::DS_TRIPPED] && !status_r[dsr_pkg::DS_READY];
  endproperty
  a_trip_not_ready: assert property (p_trip_not_ready) else $error("trip not shown");

  property p_overload;
    i_ce && !param_wr |=> status_r[dsr_pkg::DS_OVERLOAD] ==
                          ($past(i_drive.motor_current) > rated_current);
  endproperty
  a_overload: assert property (p_overload) else $error("overload flag wrong");

  property p_heatsink;
    i_ce && i_meas.heatsink_temp == dsr_pkg::HEATSINK_LIMIT_C |=> !status_r[dsr_pkg::DS_HS_HOT];
  endproperty
  a_heatsink: assert property (p_heatsink) else $error("heatsink limit off");

  property p_reverse;
    i_ce |=> status_r[dsr_pkg::DS_REVERSE] == $past(i_drive.out_speed[15]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse flag wrong");

  property p_live_toggle;
    i_ce && status_read |=> live_r != $past(live_r) && o_rsp.rdata[15] == $past(live_r);
  endproperty
  a_live_toggle: assert property (p_live_toggle) else $error("live bit not toggled");

  property p_live_hold;
    !(i_ce && status_read) |=> $stable(live_r);
  endproperty
  a_live_hold: assert property (p_live_hold) else $error("live bit moved");

  property p_din_order;
    i_ce |=> io_r[3:0] == $past(i_io.digital_in);
  endproperty
  a_din_order: assert property (p_din_order) else $error("digital input bits wrong");

  property p_reserved;
    (o_drive_status & dsr_pkg::DS_RESERVED_MASK) == 16'h0000 &&
    (o_io_status & dsr_pkg::IO_RESERVED_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_param_roundtrip;
    logic [15:0] d;
    (i_ce && param_wr, d = i_req.wdata) ##1
    (i_ce && i_req.valid && !i_req.write && i_req.reg_num == $past(i_req.reg_num))
    |=> o_rsp.rdata == d && !o_rsp.err;
  endproperty
  a_param_roundtrip: assert property (p_param_roundtrip) else $error("param readback wrong");

  property p_mon_write_err;
    i_ce && i_req.valid && i_req.write && sel == DSR_SEL_MON |=> o_rsp.valid && o_rsp.err;
  endproperty
  a_mon_write_err: assert property (p_mon_write_err) else $error("write to monitor accepted");

  property p_fire_mode;
    i_ce |=> status_r[dsr_pkg::DS_FIRE_MODE] == $past(i_drive.fire_mode);
  endproperty
  a_fire_mode: assert property (p_fire_mode) else $error("fire mode flag wrong");

  property p_at_speed;
    i_ce |=> status_r[dsr_pkg::DS_AT_SPEED] == ($past(i_drive.drive_enabled) &&
             $past(i_drive.out_speed) == $past(i_drive.speed_setpoint));
  endproperty
  a_at_speed: assert property (p_at_speed) else $error("at speed flag wrong");

  property p_below_min;
    i_ce && !i_drive.drive_enabled |=> !status_r[dsr_pkg::DS_BELOW_MIN];
  endproperty
  a_below_min: assert property (p_below_min) else $error("below min while disabled");

  property p_mains_loss;
    i_ce |=> status_r[dsr_pkg::DS_MAINS_LOSS] == $past(i_drive.mains_loss);
  endproperty
  a_mains_loss: assert property (p_mains_loss) else $error("mains loss flag wrong");

  property p_board_hot;
    i_ce && i_meas.board_temp > dsr_pkg::BOARD_LIMIT_C |=> status_r[dsr_pkg::DS_BOARD_HOT];
  endproperty
  a_board_hot: assert property (p_board_hot) else $error("board hot flag missing");

  property p_foldback;
    i_ce |=> status_r[dsr_pkg::DS_FOLDBACK] == $past(i_drive.foldback);
  endproperty
  a_foldback: assert property (p_foldback) else $error("foldback flag wrong");

  property p_switches;
    i_ce |=> io_r[dsr_pkg::IO_SW_FWD +: 2] == {$past(i_io.switch_rev), $past(i_io.switch_fwd)};
  endproperty
  a_switches: assert property (p_switches) else $error("switch bits wrong");

  property p_dout;
    i_ce && i_io.digital_out_active |=> io_r[dsr_pkg::IO_DOUT];
  endproperty
  a_dout: assert property (p_dout) else $error("digital output bit missing");

  property p_relay;
    i_ce |=> io_r[dsr_pkg::IO_RELAY] == $past(i_io.relay_closed);
  endproperty
  a_relay: assert property (p_relay) else $error("relay bit wrong");

  property p_loop_loss;
    i_ce |=> io_r[dsr_pkg::IO_AIN1_LOSS +: 2] ==
             {$past(i_io.analog_in_two_loss), $past(i_io.analog_in_one_loss)};
  endproperty
  a_loop_loss: assert property (p_loop_loss) else $error("signal loss bits wrong");

  property p_pot_half;
    i_ce && i_meas.front_pot_raw <= dsr_pkg::POT_HALF_SCALE |=> !io_r[dsr_pkg::IO_POT_HALF];
  endproperty
  a_pot_half: assert property (p_pot_half) else $error("pot half flag early");

  property p_unmapped;
    i_ce && i_req.valid && sel == DSR_SEL_NONE |=> o_rsp.err && o_rsp.rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped register answered");

  // a low enable must leave every status flop where it was
  property p_freeze;
    !i_ce |=> $stable(status_r) && $stable(io_r) && $stable(live_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule
`default_nettype wire

// ===== pkg/dsr_pkg.sv
package dsr_pkg;

  // holding-register numbers of the read-only monitoring window
  localparam logic [15:0] REG_DRIVE_STATUS_WORD  = 16'h07d1;
  localparam logic [15:0] REG_IO_STATUS_WORD     = 16'h07d5;
  localparam logic [15:0] REG_OUTPUT_TORQUE      = 16'h07d6;
  localparam logic [15:0] REG_DC_LINK_VOLTAGE    = 16'h07d7;
  localparam logic [15:0] REG_HEATSINK_TEMP      = 16'h07d8;
  localparam logic [15:0] REG_ANALOG_IN_ONE_RAW  = 16'h07d9;
  localparam logic [15:0] REG_ANALOG_IN_TWO_RAW  = 16'h07da;
  localparam logic [15:0] REG_ANALOG_OUT_LEVEL   = 16'h07db;
  localparam logic [15:0] REG_LOOP_CTRL_OUTPUT   = 16'h07dc;
  localparam logic [15:0] REG_BOARD_TEMP         = 16'h07dd;
  localparam logic [15:0] REG_OUTPUT_VOLTAGE     = 16'h07de;
  localparam logic [15:0] REG_FRONT_POT_RAW      = 16'h07df;
  localparam logic [15:0] REG_FAULT_CODE         = 16'h07e0;

  // configuration parameters: register number = base + parameter number
  localparam logic [15:0] PARAM_REG_BASE   = 16'h0080;
  localparam logic [15:0] PARAM_FIRST      = 16'h0004;
  localparam logic [15:0] PARAM_LAST       = 16'h003c;
  localparam int          PARAM_COUNT      = 57;
  localparam logic [15:0] PARAM_RESET      = 16'h0000;
  localparam logic [15:0] PARAM_RATED_CURR = 16'h0008;

  // drive status word bit positions
  localparam int DS_READY      = 0;
  localparam int DS_RUNNING    = 1;
  localparam int DS_TRIPPED    = 2;
  localparam int DS_STANDBY    = 3;
  localparam int DS_FIRE_MODE  = 4;
  localparam int DS_AT_SPEED   = 6;
  localparam int DS_BELOW_MIN  = 7;
  localparam int DS_OVERLOAD   = 8;
  localparam int DS_MAINS_LOSS = 9;
  localparam int DS_HS_HOT     = 10;
  localparam int DS_BOARD_HOT  = 11;
  localparam int DS_FOLDBACK   = 12;
  localparam int DS_REVERSE    = 13;
  localparam int DS_LIVE       = 15;
  localparam logic [15:0] DS_RESERVED_MASK = 16'h4020;

  // io status word bit positions
  localparam int IO_DIN_LSB    = 0;
  localparam int IO_SW_FWD     = 6;
  localparam int IO_SW_REV     = 7;
  localparam int IO_DOUT       = 8;
  localparam int IO_RELAY      = 9;
  localparam int IO_AIN1_LOSS  = 12;
  localparam int IO_AIN2_LOSS  = 13;
  localparam int IO_POT_HALF   = 15;
  localparam logic [15:0] IO_RESERVED_MASK = 16'h4c30;

  // thresholds
  localparam logic signed [15:0] HEATSINK_LIMIT_C = 16'sh0055;
  localparam logic signed [15:0] BOARD_LIMIT_C    = 16'sh0050;
  localparam logic [15:0]        POT_HALF_SCALE   = 16'h0800;

  localparam logic [15:0] STATUS_RESET = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] reg_num;
    logic [15:0] wdata;
  } dsr_req_type;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] rdata;
  } dsr_rsp_type;

  typedef struct packed {
    logic        trip;
    logic        mains_loss;
    logic        hw_enable;
    logic        running;
    logic        standby;
    logic        fire_mode;
    logic        drive_enabled;
    logic        foldback;
    logic signed [15:0] out_speed;
    logic signed [15:0] speed_setpoint;
    logic [15:0] min_speed;
    logic [15:0] motor_current;
  } dsr_drive_type;

  typedef struct packed {
    logic [3:0]  digital_in;
    logic        switch_fwd;
    logic        switch_rev;
    logic        digital_out_active;
    logic        relay_closed;
    logic        analog_in_one_loss;
    logic        analog_in_two_loss;
  } dsr_io_type;

  typedef struct packed {
    logic [15:0] output_torque;
    logic [15:0] dc_link_voltage;
    logic signed [15:0] heatsink_temp;
    logic [15:0] analog_in_one_raw;
    logic [15:0] analog_in_two_raw;
    logic [15:0] analog_out_level;
    logic [15:0] loop_controller_output;
    logic signed [15:0] board_temp;
    logic [15:0] output_voltage;
    logic [15:0] front_pot_raw;
    logic [15:0] fault_code;
  } dsr_meas_type;

endpackage

// ===== rtl/dsr_param_store.sv
`timescale 1ns/100ps
`default_nettype none
module dsr_param_store (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_wr,
  input  wire logic [5:0]  i_idx,
  input  wire logic [15:0] i_wdata,
  input  wire logic [5:0]  i_rd_idx,
  output logic      [15:0] o_rdata,
  output logic      [15:0] o_rated_current
);

  logic [15:0] mem_r [dsr_pkg::PARAM_COUNT];

  // one flop word per parameter; index 0 holds the lowest exposed parameter
  genvar g;
  generate
    for (g = 0; g < dsr_pkg::PARAM_COUNT; g++) begin : g_word
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mem_r[g] <= dsr_pkg::PARAM_RESET;
        end else if (i_ce && i_wr && i_idx == 6'(g)) begin
          mem_r[g] <= i_wdata;
        end
      end
    end
  endgenerate

  assign o_rdata         = mem_r[i_rd_idx];
  assign o_rated_current = mem_r[6'(dsr_pkg::PARAM_RATED_CURR - dsr_pkg::PARAM_FIRST)];

endmodule
`default_nettype wire

// ===== sim/dsr_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsr_master_model (
  input  wire logic                 i_clk,
  output dsr_pkg::dsr_req_type      o_req,
  input  wire dsr_pkg::dsr_rsp_type i_rsp
);
  initial o_req = '0;

  // one word per request: a block read goes out as a run of single reads
  task automatic xfer(input logic wr, input logic [15:0] num, input logic [15:0] wd,
                      output logic [15:0] rd, output logic er, output logic ok);
    @(posedge i_clk);
    #10;
    o_req = '{valid: 1'b1, write: wr, reg_num: num, wdata: wd};
    @(posedge i_clk);
    #10;
    ok = (i_rsp.valid === 1'b1);
    rd = i_rsp.rdata;
    er = i_rsp.err;
    // released lines show the inverse so a stale request cannot pass for a live one
    o_req = '{valid: 1'b0, write: ~wr, reg_num: ~num, wdata: ~wd};
  endtask

  // write then read of one register, valid held high across the boundary
  task automatic wr_rd(input logic [15:0] num, input logic [15:0] wd,
                       output logic [15:0] rd, output logic er);
    @(posedge i_clk);
    #10;
    o_req = '{valid: 1'b1, write: 1'b1, reg_num: num, wdata: wd};
    @(posedge i_clk);
    #10;
    er = i_rsp.err | (i_rsp.valid !== 1'b1);
    o_req = '{valid: 1'b1, write: 1'b0, reg_num: num, wdata: wd};
    @(posedge i_clk);
    #10;
    er = er | i_rsp.err | (i_rsp.valid !== 1'b1);
    rd = i_rsp.rdata;
    o_req = '{valid: 1'b0, write: 1'b1, reg_num: ~num, wdata: ~wd};
  endtask

  function automatic logic [15:0] param_reg(input logic [15:0] n);
    return dsr_pkg::PARAM_REG_BASE + n;
  endfunction
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                   clk;
  logic                   rst_n;
  logic                   ce;
  dsr_pkg::dsr_req_type   req;
  dsr_pkg::dsr_rsp_type   rsp;
  dsr_pkg::dsr_drive_type drv;
  dsr_pkg::dsr_io_type    io;
  dsr_pkg::dsr_meas_type  meas;
  logic [15:0]            ds;
  logic [15:0]            ios;
  logic [15:0]            rd;
  logic                   er;
  logic                   ok;
  logic                   live_exp;
  int                     error_cnt;
  int                     samples_checked;

  dsr_drive_status_register_bank DUT (.i_clk(clk), .i_resetn(rst_n), .i_ce(ce),
    .i_req(req), .o_rsp(rsp), .i_drive(drv), .i_io(io), .i_meas(meas),
    .o_drive_status(ds), .o_io_status(ios));
  dsr_master_model MST (.i_clk(clk), .o_req(req), .i_rsp(rsp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [15:0] num, input logic [15:0] wd);
    MST.xfer(wr, num, wd, rd, er, ok);
    if (!ok) begin
      error_cnt++;
      $display("BAD rsp_valid expected 1 seen 0");
      report_and_stop();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    #10;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #10;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #10;
    live_exp = 1'b0;
    chk16("drive_status_reset", 16'h0000, ds);
    chk16("io_status_reset", 16'h0000, ios);
    chk1("rsp_valid_reset", 1'b0, rsp.valid);
  endtask

  // flags need one enabled edge to land, so wait before reading
  task automatic chk_status(input logic [15:0] e);
    repeat (2) @(posedge clk);
    acc(1'b0, dsr_pkg::REG_DRIVE_STATUS_WORD, 16'h0000);
    chk16("drive_status", {live_exp, e[14:0]}, rd);
    live_exp = ~live_exp;
    chk16("drive_status_port", {live_exp, e[14:0]}, ds);
  endtask

  task automatic chk_io(input logic [15:0] e);
    repeat (2) @(posedge clk);
    acc(1'b0, dsr_pkg::REG_IO_STATUS_WORD, 16'h0000);
    chk16("io_status", e, rd);
    chk16("io_status_port", e, ios);
  endtask

  task automatic t_params();
    logic [15:0] pn [3] = '{16'h0004, 16'h000f, 16'h003c};
    logic [15:0] rn [3] = '{16'h0084, 16'h008f, 16'h00bc};
    logic [15:0] bad [4] = '{16'h0083, 16'h00bd, 16'h07d2, 16'h07e1};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, MST.param_reg(pn[i]), 16'ha5a0 + 16'(i));
      chk1("param_wr_err", 1'b0, er);
    end
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, rn[i], 16'h0000);
      chk16("param_rd", 16'ha5a0 + 16'(i), rd);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, bad[i], 16'h0000);
      chk1("unmapped_err", 1'b1, er);
      chk16("unmapped_rd", 16'h0000, rd);
    end
    acc(1'b1, dsr_pkg::REG_DRIVE_STATUS_WORD, 16'hffff);
    chk1("ro_wr_err", 1'b1, er);
    acc(1'b1, dsr_pkg::REG_FAULT_CODE, 16'hffff);
    chk1("ro_wr_err", 1'b1, er);
    MST.wr_rd(16'h0090, 16'h5a0f, rd, er);
    chk1("wr_rd_err", 1'b0, er);
    chk16("wr_rd_data", 16'h5a0f, rd);
  endtask

  task automatic t_status();
    // one flag at a time, foldback upwards to trip
    logic [15:0] ex [8] = '{16'h1000, 16'h0040, 16'h0010, 16'h0008,
                            16'h0002, 16'h0001, 16'h0200, 16'h0004};
    for (int k = 0; k < 8; k++) begin
      drv = '0;
      drv[64 + k] = 1'b1;
      chk_status(ex[k]);
    end
    drv = '0;
    drv.hw_enable = 1'b1;
    drv.trip = 1'b1;
    chk_status(16'h0004);
    drv.trip = 1'b0;
    drv.mains_loss = 1'b1;
    chk_status(16'h0200);
    drv = '0;
    drv.drive_enabled = 1'b1;
    drv.out_speed = -16'sh0014;
    drv.speed_setpoint = 16'sh0064;
    drv.min_speed = 16'h0032;
    chk_status(16'h2080);
    drv.out_speed = 16'sh0064;
    chk_status(16'h0040);
    drv.out_speed = 16'sh0032;
    chk_status(16'h0000);
    drv.drive_enabled = 1'b0;
    drv.out_speed = -16'sh0014;
    drv.speed_setpoint = -16'sh0014;
    chk_status(16'h2000);
    drv = '0;
    acc(1'b1, 16'h0088, 16'h0010);
    drv.motor_current = 16'h0011;
    chk_status(16'h0100);
    drv.motor_current = 16'h0010;
    chk_status(16'h0000);
    meas.heatsink_temp = 16'sh0056;
    chk_status(16'h0400);
    meas.heatsink_temp = 16'sh0055;
    meas.board_temp = 16'sh0051;
    chk_status(16'h0800);
    meas.board_temp = 16'sh0050;
    chk_status(16'h0000);
  endtask

  task automatic t_io();
    logic [15:0] ex [10] = '{16'h2000, 16'h1000, 16'h0200, 16'h0100, 16'h0080,
                             16'h0040, 16'h0001, 16'h0002, 16'h0004, 16'h0008};
    for (int k = 0; k < 10; k++) begin
      io = '0;
      io[k] = 1'b1;
      chk_io(ex[k]);
    end
    io = '0;
    meas.analog_out_level = 16'h0001;
    chk_io(16'h0100);
    meas.analog_out_level = 16'h0000;
    meas.front_pot_raw = 16'h0800;
    chk_io(16'h0000);
    io = '1;
    meas.front_pot_raw = 16'h0801;
    chk_io(16'hb3cf);
  endtask

  task automatic t_meas();
    for (int i = 0; i < 11; i++) begin
      meas[(10 - i) * 16 +: 16] = 16'h0c10 + 16'(i);
    end
    for (int i = 0; i < 11; i++) begin
      acc(1'b0, dsr_pkg::REG_OUTPUT_TORQUE + 16'(i), 16'h0000);
      chk16("meas_rd", 16'h0c10 + 16'(i), rd);
    end
  endtask

  // a low enable must hold the drive status word still even while hw_enable moves
  task automatic t_ce();
    logic [15:0] held;
    held = ds;
    ce = 1'b0;
    drv.hw_enable = ~drv.hw_enable;
    repeat (3) @(posedge clk);
    #10;
    chk16("status_frozen", held, ds);
    ce = 1'b1;
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    drv = '0;
    io = '0;
    meas = '0;
    live_exp = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    do_reset();
    t_params();
    t_status();
    t_io();
    t_meas();
    t_ce();
    drv = '0;
    io = '0;
    meas = '0;
    do_reset();
    acc(1'b0, 16'h008f, 16'h0000);
    chk16("param_after_reset", dsr_pkg::PARAM_RESET, rd);
    chk_status(16'h0000);
    report_and_stop();
  end

  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
